// File: design/pcrc_top.sv
// Purpose: Programmable CRC generator with input FIFO behind an APB slave.
// Assumes: Zero-latency decode; every access answers in its second access cycle.
// Notes:   Registers are 16 bits wide in the low half of each word.
`timescale 1ns/1ps
`include "pcrc_params.svh"
module pcrc_top
  import pcrc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device power state and event
  input  wire logic        device_idle,
  output logic             crc_irq
);

  // ========================================================================
  // Helpers
  function automatic logic [4:0] fifo_depth(logic [4:0] dw);
    if (dw > 5'd15) begin
      return `PCRC_DEPTH_WIDE;
    end else if (dw > 5'd7) begin
      return `PCRC_DEPTH_MID;
    end
    return `PCRC_DEPTH_NARR;
  endfunction

  function automatic pcrc_word_t width_mask(logic [4:0] dw);
    return 32'hFFFF_FFFF >> (5'd31 - dw);
  endfunction

  // ========================================================================
  // State
  logic             en_q;
  logic             idle_stop_q;
  logic             isel_q;
  logic             go_q;
  logic             lsb_q;
  logic [4:0]       dw_q;
  logic [4:0]       poly_length_field_q;
  logic [15:1]      terms_lo_q;
  logic [15:0]      terms_hi_q;
  pcrc_word_t       stage_q;
  pcrc_word_t       fifo_mem [16];
  logic [3:0]       wr_ptr_q;
  logic [3:0]       rd_ptr_q;
  logic [4:0]       cnt_q;
  logic [4:0]       cnt_d;
  pcrc_state_t      st_q;
  pcrc_state_t      st_d;
  pcrc_word_t       buf_q;
  pcrc_word_t       buf_d;
  logic [5:0]       bits_q;
  logic [5:0]       bits_d;
  pcrc_word_t       crc_q;
  pcrc_word_t       crc_d;
  logic             go_d;
  logic             irq_d;
  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      prdata_q;

  // ========================================================================
  // APB decode
  wire        acc_first = psel & penable & ~pready_q;
  wire        wr_fire   = psel & penable & pready_q & pwrite;
  wire        sel_c1    = (paddr == `PCRC_OFF_CTRL1);
  wire        sel_c2    = (paddr == `PCRC_OFF_CTRL2);
  wire        sel_tlo   = (paddr == `PCRC_OFF_TERMS_LO);
  wire        sel_thi   = (paddr == `PCRC_OFF_TERMS_HI);
  wire        sel_dlo   = (paddr == `PCRC_OFF_DATA_LO);
  wire        sel_dhi   = (paddr == `PCRC_OFF_DATA_HI);
  wire        sel_rlo   = (paddr == `PCRC_OFF_RESULT_LO);
  wire        sel_rhi   = (paddr == `PCRC_OFF_RESULT_HI);
  wire        sel_any   = sel_c1 | sel_c2 | sel_tlo | sel_thi |
                          sel_dlo | sel_dhi | sel_rlo | sel_rhi;
  wire        wr_c1     = wr_fire & sel_c1;
  wire        wr_c2     = wr_fire & sel_c2;
  wire        wr_dlo    = wr_fire & sel_dlo & en_q;
  wire        wr_dhi    = wr_fire & sel_dhi & en_q;
  wire        wr_rlo    = wr_fire & sel_rlo & en_q;
  wire        wr_rhi    = wr_fire & sel_rhi & en_q;

  // ========================================================================
  // FIFO fill side
  wire [4:0]  depth     = fifo_depth(dw_q);
  wire        full      = (cnt_q >= depth);
  wire        empty     = (cnt_q == 5'd0);
  wire        wide_word = (dw_q > 5'd15);
  wire [31:0] stage_new = {wr_dhi ? pwdata[15:0] : stage_q[31:16],
                           wr_dlo ? pwdata[15:0] : stage_q[15:0]};
  wire        push_req  = (wr_dlo & ~wide_word) | (wr_dhi & wide_word);
  wire        push      = push_req & ~full;
  wire [31:0] push_word = stage_new & width_mask(dw_q);

  // ========================================================================
  // Engine side
  wire        run       = en_q & ~(idle_stop_q & device_idle);
  wire        last_bits = (bits_q <= 6'd2);
  wire        start_pop = (st_q == PCRC_IDLE) & go_q & ~empty;
  wire        next_pop  = (st_q == PCRC_SHIFT) & go_q & last_bits & ~empty;
  wire        pop       = run & (start_pop | next_pop);
  wire        finish    = run & (st_q == PCRC_SHIFT) & go_q & last_bits & empty;
  wire [31:0] pop_word  = fifo_mem[rd_ptr_q];
  wire [31:0] pop_align = lsb_q ? pop_word : (pop_word << (5'd31 - dw_q));
  wire [5:0]  width_bits = {1'b0, dw_q} + 6'd1;

  pcrc_step_if step_if ();

  assign step_if.crc_in   = crc_q;
  assign step_if.taps     = {terms_hi_q, terms_lo_q, 1'b1};
  assign step_if.poly_len = poly_length_field_q;
  assign step_if.din      = lsb_q ? {buf_q[0], buf_q[1]} : {buf_q[31], buf_q[30]};
  assign step_if.two_bits = (bits_q != 6'd1);

  pcrc_engine u_engine (
    .step (step_if)
  );

  // ========================================================================
  // Next-state logic
  always_comb begin
    st_d   = st_q;
    buf_d  = buf_q;
    bits_d = bits_q;
    crc_d  = crc_q;
    go_d   = go_q;
    irq_d  = 1'b0;
    cnt_d  = cnt_q + {4'd0, push} - {4'd0, pop};
    if (run && st_q == PCRC_SHIFT && go_q) begin
      crc_d = step_if.crc_out;
      if (step_if.two_bits) begin
        buf_d  = lsb_q ? (buf_q >> 2) : (buf_q << 2);
        bits_d = bits_q - 6'd2;
      end else begin
        bits_d = 6'd0;
      end
    end
    if (run && st_q == PCRC_SHIFT && !go_q) begin
      st_d = PCRC_IDLE;
    end
    if (pop) begin
      buf_d  = pop_align;
      bits_d = width_bits;
      st_d   = PCRC_SHIFT;
    end
    if (finish) begin
      go_d = 1'b0;
      st_d = PCRC_IDLE;
      irq_d = isel_q;
    end
    if (!isel_q && cnt_q == 5'd1 && cnt_d == 5'd0) begin
      irq_d = 1'b1;
    end
    if (wr_c1) begin
      go_d = pwdata[`PCRC_C1_GO];
    end
    if (wr_rlo) begin
      crc_d[15:0] = pwdata[15:0];
    end
    if (wr_rhi) begin
      crc_d[31:16] = pwdata[15:0];
    end
    if (!en_q) begin
      st_d   = PCRC_IDLE;
      buf_d  = `PCRC_RST_WORD;
      bits_d = 6'd0;
      crc_d  = `PCRC_RST_WORD;
      cnt_d  = `PCRC_RST_FIELD;
      irq_d  = 1'b0;
      if (!wr_c1) begin
        go_d = 1'b0;
      end
    end
  end

  // ========================================================================
  // Read data
  wire [15:0] c1_rd = {en_q, 1'b0, idle_stop_q, cnt_q, full, empty,
                       isel_q, go_q, lsb_q, 3'b000};
  wire [15:0] c2_rd = {3'b000, dw_q, 3'b000, poly_length_field_q};
  wire [15:0] rd_half = sel_c1  ? c1_rd :
                        sel_c2  ? c2_rd :
                        sel_tlo ? {terms_lo_q, 1'b0} :
                        sel_thi ? terms_hi_q :
                        sel_dlo ? stage_q[15:0] :
                        sel_dhi ? stage_q[31:16] :
                        sel_rlo ? crc_q[15:0] :
                        sel_rhi ? crc_q[31:16] : `PCRC_RST_HALF;

  // ========================================================================
  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `PCRC_RST_WORD;
    end else begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first & ~sel_any;
      prdata_q  <= (acc_first & ~pwrite) ? {16'h0000, rd_half} : `PCRC_RST_WORD;
    end
  end

  // ========================================================================
  // Configuration registers, kept across enable changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q        <= 1'b0;
      idle_stop_q <= 1'b0;
      isel_q      <= 1'b0;
      lsb_q       <= 1'b0;
      dw_q        <= `PCRC_RST_FIELD;
      poly_length_field_q      <= `PCRC_RST_FIELD;
      terms_lo_q  <= 15'h0000;
      terms_hi_q  <= `PCRC_RST_HALF;
    end else begin
      if (wr_c1) begin
        en_q        <= pwdata[`PCRC_C1_EN];
        idle_stop_q <= pwdata[`PCRC_C1_IDLE_STOP];
        isel_q      <= pwdata[`PCRC_C1_ISEL];
        lsb_q       <= pwdata[`PCRC_C1_LSB];
      end
      if (wr_c2) begin
        dw_q   <= pwdata[`PCRC_C2_DW_HI:`PCRC_C2_DW_LO];
        poly_length_field_q <= pwdata[`PCRC_C2_PL_HI:`PCRC_C2_PL_LO];
      end
      if (wr_fire && sel_tlo) begin
        terms_lo_q <= pwdata[15:1];
      end
      if (wr_fire && sel_thi) begin
        terms_hi_q <= pwdata[15:0];
      end
    end
  end

  // ========================================================================
  // Working state, cleared while the module is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= PCRC_IDLE;
      buf_q    <= `PCRC_RST_WORD;
      bits_q   <= 6'd0;
      crc_q    <= `PCRC_RST_WORD;
      cnt_q    <= `PCRC_RST_FIELD;
      go_q     <= 1'b0;
      crc_irq  <= 1'b0;
    end else begin
      st_q     <= st_d;
      buf_q    <= buf_d;
      bits_q   <= bits_d;
      crc_q    <= crc_d;
      cnt_q    <= cnt_d;
      go_q     <= go_d;
      crc_irq  <= irq_d;
    end
  end

  // ========================================================================
  // FIFO pointers and staging word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      stage_q  <= `PCRC_RST_WORD;
    end else if (!en_q) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      stage_q  <= `PCRC_RST_WORD;
    end else begin
      stage_q <= stage_new;
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
    end
  end

  // Storage has no reset; the pointers guard against stale words.
  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_mem[wr_ptr_q] <= push_word;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule

// File: design/pcrc_params.svh
// Purpose: Register map, field positions and reset values of the CRC engine.
// Assumes: 32-bit APB data, each 16-bit register in the low half of one word.
// Notes:   Definitions only.
//
// Notes on behaviour
// - Input word width is the five-bit width field plus one, 1 to 32.
// - FIFO depth is 4 above width field 15, 8 for 8..15, else 16.
// - Narrow words are written to the low data register; bits above the width are ignored.
// - Valid-word count rises on the write covering the word's top bit.
// - Shifting starts with start set and count nonzero; each pop decrements count.
// - The engine shifts two bits per cycle; a 32-bit word takes 16 cycles.
// - Full flag asserts when the count reaches the width's depth.
// - Empty flag asserts while the count is zero; it reads one after reset.
// - Enable low empties the FIFO, zeroes the count and resets working state.
// - Direction bit 3 selects MSb first or LSb first; result stays normal.
// - With select zero, an interrupt fires when the count goes one to zero.
// - With select one, an interrupt fires when hardware clears start.
// - Hardware clears the start bit when the calculation completes.
// - Polynomial length is the five-bit length field plus one.
// - Low term register holds X15..X1, bit 0 zero; high holds X31..X16.
// - Idle-stop bit 13 halts the engine in device idle when set.
// - Each set term bit adds an XOR feedback tap at that exponent.
// - The zero term is always applied; the top term is implied.
`ifndef PCRC_PARAMS_SVH
`define PCRC_PARAMS_SVH

// ==========================================================================
// Register offsets
`define PCRC_OFF_CTRL1     12'h000
`define PCRC_OFF_CTRL2     12'h004
`define PCRC_OFF_TERMS_LO  12'h008
`define PCRC_OFF_TERMS_HI  12'h00C
`define PCRC_OFF_DATA_LO   12'h010
`define PCRC_OFF_DATA_HI   12'h014
`define PCRC_OFF_RESULT_LO 12'h018
`define PCRC_OFF_RESULT_HI 12'h01C

// ==========================================================================
// Field positions
`define PCRC_C1_EN        15
`define PCRC_C1_IDLE_STOP 13
`define PCRC_C1_CNT_HI    12
`define PCRC_C1_CNT_LO    8
`define PCRC_C1_FULL      7
`define PCRC_C1_EMPTY     6
`define PCRC_C1_ISEL      5
`define PCRC_C1_GO        4
`define PCRC_C1_LSB       3
`define PCRC_C2_DW_HI     12
`define PCRC_C2_DW_LO     8
`define PCRC_C2_PL_HI     4
`define PCRC_C2_PL_LO     0

// ==========================================================================
// Reset values and depths
`define PCRC_RST_HALF   16'h0000
`define PCRC_RST_WORD   32'h0000_0000
`define PCRC_RST_FIELD  5'h00
`define PCRC_DEPTH_WIDE 5'h04
`define PCRC_DEPTH_MID  5'h08
`define PCRC_DEPTH_NARR 5'h10

`endif

// File: design/pcrc_pkg.sv
// Purpose: Types shared by the CRC engine modules.
// Assumes: Nothing beyond the parameter header.
// Notes:   Gray-coded state along idle to shift.
package pcrc_pkg;

  typedef enum logic [0:0] {
    PCRC_IDLE  = 1'b0,
    PCRC_SHIFT = 1'b1
  } pcrc_state_t;

  typedef logic [31:0] pcrc_word_t;

endpackage

// File: design/pcrc_step_if.sv
// Purpose: Carries one two-bit step request between control and feedback logic.
// Assumes: Purely combinational exchange within one clock.
// Notes:   din[1] is the first bit applied.
`timescale 1ns/1ps
interface pcrc_step_if;
  import pcrc_pkg::*;
  pcrc_word_t  crc_in;
  pcrc_word_t  taps;
  logic [4:0]  poly_len;
  logic [1:0]  din;
  logic        two_bits;
  pcrc_word_t  crc_out;

  modport ctrl (output crc_in, taps, poly_len, din, two_bits, input crc_out);
  modport eng  (input crc_in, taps, poly_len, din, two_bits, output crc_out);
endinterface

// File: design/pcrc_engine.sv
// Purpose: Feedback network advancing the CRC state by one or two bits.
// Assumes: taps bit 0 is already forced to one by the caller.
// Notes:   Bits above the polynomial length are held at zero.
`timescale 1ns/1ps
module pcrc_engine
  import pcrc_pkg::*;
(
  // Step request and result
  pcrc_step_if.eng step
);

  // ========================================================================
  // One bit of a normal, non-reflected CRC
  function automatic pcrc_word_t crc_bit(pcrc_word_t cur, pcrc_word_t taps,
                                         logic [4:0] poly_length_field, logic b);
    pcrc_word_t mask;
    pcrc_word_t nxt;
    logic       fb;
    mask = 32'hFFFF_FFFF >> (5'd31 - poly_length_field);
    fb   = cur[poly_length_field] ^ b;
    nxt  = {cur[30:0], 1'b0};
    if (fb) begin
      nxt = nxt ^ taps;
    end
    return nxt & mask;
  endfunction

  pcrc_word_t first_w;
  pcrc_word_t second_w;

  assign first_w      = crc_bit(step.crc_in, step.taps, step.poly_len, step.din[1]);
  assign second_w     = crc_bit(first_w, step.taps, step.poly_len, step.din[0]);
  assign step.crc_out = step.two_bits ? second_w : first_w;

endmodule

// File: verif/pcrc_apb_host.sv
// Purpose: APB master standing in for the processor core.
// Assumes: Each task is entered just after a rising clock edge.
// Notes:   One idle cycle follows every transfer.
`timescale 1ns/1ps
module pcrc_apb_host (
  // Clock
  input  wire logic        pclk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rd_q;
  logic        err_q;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // ==========================================================================
  // Transfer
  // The idle cycle keeps a data write apart from a following count read.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// File: verif/pcrc_assertions.sv
// Purpose: Port checker for the CRC engine.
// Assumes: One clock domain.
// Notes:   Bound to the top module.
`timescale 1ns/1ps
module pcrc_assertions (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Watched ports
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        crc_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Sequences
  sequence s_setup;    psel && !penable; endsequence
  sequence s_access;   psel && penable; endsequence
  sequence s_rd_ctrl1; pready && !pwrite && paddr == 12'h000; endsequence

  // ==========================================================================
  // Properties
  property p_one_wait; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_map;
    pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h01C);
  endproperty
  property p_rdata_idle; !(pready && !pwrite) |-> prdata == 32'h0000_0000; endproperty
  property p_empty; s_rd_ctrl1 |-> prdata[6] == (prdata[12:8] == 5'h00); endproperty
  property p_count_max; s_rd_ctrl1 |-> prdata[12:8] <= 5'h10; endproperty
  property p_full_depth;
    s_rd_ctrl1 ##0 prdata[7] |-> prdata[12:8] inside {5'h04, 5'h08, 5'h10};
  endproperty
  property p_terms_bit0; pready && !pwrite && paddr == 12'h008 |-> !prdata[0]; endproperty
  property p_ctrl2_zero;
    pready && !pwrite && paddr == 12'h004 |-> prdata[15:13] == 3'b000 && prdata[7:5] == 3'b000;
  endproperty
  property p_irq_pulse; crc_irq |=> !crc_irq; endproperty

  a_one_wait: assert property (p_one_wait) else $error("answer not in second access cycle");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  a_err_map: assert property (p_err_map) else $error("slave error wrong for address");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  a_empty: assert property (p_empty) else $error("empty flag wrong");
  a_count_max: assert property (p_count_max) else $error("count above depth");
  a_full_depth: assert property (p_full_depth) else $error("full at wrong count");
  a_terms_bit0: assert property (p_terms_bit0) else $error("term bit 0 set");
  a_ctrl2_zero: assert property (p_ctrl2_zero) else $error("unused bits set");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a cycle");
endmodule

bind pcrc_top pcrc_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .crc_irq(crc_irq));

// File: verif/tb.sv
// Purpose: Self-checking bench for the CRC engine.
// Assumes: Register map from the parameter header.
// Notes:   Bus traffic goes through the host model.
`timescale 1ns/1ps
`include "pcrc_params.svh"
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
  logic        pclk;
  logic        presetn;
  logic        device_idle;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        crc_irq;
  int          fail_count;
  int          checks;

  always #10 pclk = ~pclk;

  pcrc_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pcrc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .device_idle(device_idle), .crc_irq(crc_irq));

  // ==========================================================================
  // Bus helpers
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    host.xfer(1'b0, a, 16'h0000);
    d = host.rd_q[15:0];
  endtask
  task automatic push(input logic [4:0] dw, input logic [31:0] w);
    wr(`PCRC_OFF_DATA_LO, w[15:0]);
    if (dw > 5'd15) wr(`PCRC_OFF_DATA_HI, w[31:16]);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [15:0] v;
    rd(`PCRC_OFF_CTRL1, v);
    `CHK(v, 16'h0040, "control one reset")
    rd(12'h020, v);
    `CHK({host.err_q, v}, 17'h1_0000, "unmapped read")
  endtask

  task automatic t_regs;
    logic [15:0] v;
    wr(`PCRC_OFF_TERMS_LO, 16'hffff);
    rd(`PCRC_OFF_TERMS_LO, v);
    `CHK(v, 16'hfffe, "terms low")
    wr(`PCRC_OFF_TERMS_HI, 16'hffff);
    rd(`PCRC_OFF_TERMS_HI, v);
    `CHK(v, 16'hffff, "terms high")
    wr(`PCRC_OFF_CTRL2, 16'hffff);
    rd(`PCRC_OFF_CTRL2, v);
    `CHK(v, 16'h1f1f, "control two")
  endtask

  task automatic t_depth;
    logic [4:0]  dws[5] = '{5'd31, 5'd16, 5'd15, 5'd8, 5'd7};
    logic [4:0]  dep[5] = '{5'd4, 5'd4, 5'd8, 5'd8, 5'd16};
    logic [15:0] v;
    for (int i = 0; i < 5; i++) begin
      wr(`PCRC_OFF_CTRL1, 16'h0000);
      rd(`PCRC_OFF_CTRL1, v);
      `CHK(v[12:6], 7'h01, "count cleared")
      wr(`PCRC_OFF_CTRL2, {3'b000, dws[i], 8'h0f});
      wr(`PCRC_OFF_CTRL1, 16'h8000);
      wr(`PCRC_OFF_DATA_LO, 16'h0001);
      rd(`PCRC_OFF_CTRL1, v);
      `CHK(v[12:8], (dws[i] > 5'd15) ? 5'd0 : 5'd1, "top bit write counts")
      for (int k = 0; k <= dep[i]; k++) push(dws[i], k);
      rd(`PCRC_OFF_CTRL1, v);
      `CHK(v[12:6], {dep[i], 2'b10}, "full at depth")
    end
  endtask

  task automatic t_crc(input logic lsb, input logic isel, input logic [15:0] seed,
                       input logic stop);
    logic [31:0] w[2] = '{32'h1234_5678, 32'hcafe_0001};
    logic [15:0] base;
    logic [15:0] v;
    logic [15:0] c;
    logic        b;
    logic        hit;
    c = seed;
    for (int i = 0; i < 64; i++) begin
      b = lsb ? w[i / 32][i % 32] : w[i / 32][31 - i % 32];
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h1021 : 16'h0000);
    end
    base = {2'b10, stop, 7'h00, isel, 1'b0, lsb, 3'b000};
    wr(`PCRC_OFF_CTRL1, 16'h0000);
    wr(`PCRC_OFF_CTRL2, 16'h1f0f);
    wr(`PCRC_OFF_TERMS_LO, 16'h1020);
    wr(`PCRC_OFF_TERMS_HI, 16'h0000);
    wr(`PCRC_OFF_CTRL1, base);
    push(5'd31, w[0]);
    push(5'd31, w[1]);
    wr(`PCRC_OFF_RESULT_LO, seed);
    wr(`PCRC_OFF_RESULT_HI, 16'h0000);
    device_idle <= stop;
    wr(`PCRC_OFF_CTRL1, base | 16'h0010);
    if (stop) begin
      repeat (40) @(posedge pclk);
      rd(`PCRC_OFF_CTRL1, v);
      `CHK(v[12:8], 5'd2, "halted in idle")
      device_idle <= 1'b0;
    end
    hit = 1'b0;
    for (int k = 0; k < 200 && !hit; k++) begin
      @(posedge pclk);
      hit = (crc_irq === 1'b1);
    end
    `CHK(hit, 1'b1, "event pulse")
    v = 16'h0010;
    for (int k = 0; k < 20 && v[4]; k++) rd(`PCRC_OFF_CTRL1, v);
    `CHK(v[12:4], {7'h01, isel, 1'b0}, "start cleared")
    rd(`PCRC_OFF_RESULT_LO, v);
    `CHK(v, c, "crc value")
    wr(`PCRC_OFF_CTRL1, 16'h0000);
    rd(`PCRC_OFF_RESULT_LO, v);
    `CHK(v, 16'h0000, "result cleared")
    rd(`PCRC_OFF_CTRL2, v);
    `CHK(v, 16'h1f0f, "config kept")
  endtask

  // ==========================================================================
  // Run control
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    device_idle = 1'b0;
    fail_count  = 0;
    checks      = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_regs;
    t_depth;
    t_crc(1'b0, 1'b1, 16'h0000, 1'b1);
    t_crc(1'b1, 1'b0, 16'hbeef, 1'b0);
    test_done;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    test_done;
  end
endmodule
